// ---- verilog/interrupt_enable_bank.sv ----
// Interrupt enable bank top: Avalon-MM register slave, word banks and priority pick.
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_bank (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Avalon-MM slave.
	input wire logic [irq_enable_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [irq_enable_pkg::DATA_W-1:0] writedata,
	input wire logic [irq_enable_pkg::BE_W-1:0] byteenable,
	output logic [irq_enable_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	output logic [1:0] response,
	// Source events, one pulse or level per source.
	input wire logic [irq_enable_pkg::NUM_SRC-1:0] srcEvent,
	// Priority fields, three bits per source.
	input wire logic [irq_enable_pkg::NUM_SRC*irq_enable_pkg::PRIO_W-1:0] srcPriority,
	// Requests toward the priority logic.
	output logic [irq_enable_pkg::NUM_SRC-1:0] irqReq,
	output logic [irq_enable_pkg::NUM_SRC-1:0] irqLive,
	// Winning request.
	output logic anyLive,
	output logic [irq_enable_pkg::PRIO_W-1:0] topLevel,
	output logic [irq_enable_pkg::SRC_IDX_W-1:0] topSource
);
	import irq_enable_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic waitReq_r;
	logic waitReq_nxt;
	logic [DATA_W-1:0] readData_r;
	logic [DATA_W-1:0] readData_nxt;
	logic [1:0] resp_r;
	logic [1:0] resp_nxt;
	logic busReq;
	logic takeCycle;
	logic doneCycle;
	logic [NUM_WORDS-1:0] enHit;
	logic [NUM_WORDS-1:0] flagHit;
	logic [NUM_WORDS-1:0] pendHit;
	logic statHit;
	logic mapped;
	logic [1:0] laneEn;
	word_wr_s [NUM_WORDS-1:0] wordWr;
	logic [NUM_WORDS-1:0][WORD_W-1:0] enableWords;
	logic [NUM_WORDS-1:0][WORD_W-1:0] flagWords;
	logic [NUM_WORDS-1:0][WORD_W-1:0] reqWords;
	logic [NUM_WORDS-1:0][WORD_W-1:0] liveWords;
	logic [NUM_SRC-1:0] prioOn;
	logic [NUM_SRC-1:0] liveFlat;
	logic [NUM_SRC-1:0] reqFlat;
	logic [PRIO_W-1:0] bestLvl;
	logic [SRC_IDX_W-1:0] bestIdx;
	logic bestAny;
	logic [DATA_W-1:0] statusWord;
	logic anyLive_r;
	logic [PRIO_W-1:0] topLevel_r;
	logic [SRC_IDX_W-1:0] topSource_r;
	logic [NUM_SRC*PRIO_W-1:0] prio_r;

	// ****************************************************************
	// Bus handshake
	// ****************************************************************

	// A request is present whenever the master raises read or write.
	assign busReq = read | write;

	// First cycle of a request: waitrequest is still high, data is prepared.
	assign takeCycle = busReq & waitReq_r;

	// Completion cycle: waitrequest is low, the write lands at this edge.
	assign doneCycle = busReq & ~waitReq_r;

	// Waitrequest drops for exactly one cycle per transfer, then rises again.
	always_comb begin
		waitReq_nxt = 1'b1;
		if (takeCycle) begin
			waitReq_nxt = 1'b0;
		end
	end

	// Waitrequest register, high out of reset.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			waitReq_r <= 1'b1;
		end else begin
			waitReq_r <= waitReq_nxt;
		end
	end

	// ****************************************************************
	// Address decode
	// ****************************************************************

	// One hit line per word in each register group.
	always_comb begin
		enHit = '0;
		flagHit = '0;
		pendHit = '0;
		for (int w = 0; w < NUM_WORDS; w++) begin
			if (address == EN_OFFSET[w]) begin
				enHit[w] = 1'b1;
			end else if (address == FLAG_OFFSET[w]) begin
				flagHit[w] = 1'b1;
			end else if (address == PEND_OFFSET[w]) begin
				pendHit[w] = 1'b1;
			end
		end
	end

	// Status word and the overall mapped test.
	assign statHit = (address == STATUS_OFFSET);
	assign mapped = (|enHit) | (|flagHit) | (|pendHit) | statHit;

	// Only the two low byte lanes carry register bits.
	assign laneEn = byteenable[1:0];

	// ****************************************************************
	// Write strobes toward the word banks
	// ****************************************************************

	// Writes act only in the completion cycle of a write transfer.
	always_comb begin
		for (int w = 0; w < NUM_WORDS; w++) begin
			wordWr[w].wrEnable = doneCycle & write & enHit[w];
			wordWr[w].wrFlag = doneCycle & write & flagHit[w];
			wordWr[w].laneEn = laneEn;
			wordWr[w].data = writedata[WORD_W-1:0];
		end
	end

	// ****************************************************************
	// Word banks
	// ****************************************************************

	// Source groups are cut into words, one bank per enable word.
	generate
		for (genvar g = 0; g < NUM_WORDS; g++) begin : gWord
			irq_word_bank #(
				.IMPL(IMPL_MASK[g])
			) uBank (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.wordWr(wordWr[g]),
				.eventIn(srcEvent[g*WORD_W +: WORD_W]),
				.prioOn(prioOn[g*WORD_W +: WORD_W]),
				.enableBits(enableWords[g]),
				.flagBits(flagWords[g]),
				.reqBits(reqWords[g]),
				.liveBits(liveWords[g])
			);
		end
	endgenerate

	// Flatten the word views back into source order.
	assign liveFlat = liveWords;
	assign reqFlat = reqWords;

	// ****************************************************************
	// Priority fields
	// ****************************************************************

	// A zero priority field takes the source out of the running.
	always_comb begin
		prioOn = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			prioOn[i] = (srcPriority[i*PRIO_W +: PRIO_W] != PRIO_OFF);
		end
	end

	// Priority copy taken at the same edge as the live requests.
	// The pick must see the levels that gated those requests, or a field
	// dropped to zero would leave a live request with no winner for a cycle.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prio_r <= '0;
		end else begin
			prio_r <= srcPriority;
		end
	end

	// Pick the highest level; among equals the lowest source number wins.
	always_comb begin
		bestLvl = PRIO_OFF;
		bestIdx = '0;
		bestAny = 1'b0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (liveFlat[i] && (prio_r[i*PRIO_W +: PRIO_W] > bestLvl)) begin
				bestLvl = prio_r[i*PRIO_W +: PRIO_W];
				bestIdx = SRC_IDX_W'(i);
				bestAny = 1'b1;
			end
		end
	end

	// Winner registers, refreshed every clock.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			anyLive_r <= 1'b0;
			topLevel_r <= PRIO_OFF;
			topSource_r <= '0;
		end else begin
			anyLive_r <= bestAny;
			topLevel_r <= bestLvl;
			topSource_r <= bestIdx;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************

	// Status word packs the current winner for software polling.
	always_comb begin
		statusWord = '0;
		statusWord[STAT_SRC_LSB +: SRC_IDX_W] = topSource_r;
		statusWord[STAT_LVL_LSB +: PRIO_W] = topLevel_r;
		statusWord[STAT_ANY_BIT] = anyLive_r;
	end

	// Read data is built in the first cycle; unmapped reads return zero.
	always_comb begin
		readData_nxt = readData_r;
		if (takeCycle) begin
			readData_nxt = '0;
			if (read) begin
				for (int w = 0; w < NUM_WORDS; w++) begin
					if (enHit[w]) begin
						readData_nxt[WORD_W-1:0] = enableWords[w];
					end else if (flagHit[w]) begin
						readData_nxt[WORD_W-1:0] = flagWords[w];
					end else if (pendHit[w]) begin
						readData_nxt[WORD_W-1:0] = reqWords[w];
					end
				end
				if (statHit) begin
					readData_nxt = statusWord;
				end
			end
		end
	end

	// Read data register, held until the next transfer begins.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			readData_r <= '0;
		end else begin
			readData_r <= readData_nxt;
		end
	end

	// Response marks unmapped addresses and writes to read-only words.
	always_comb begin
		resp_nxt = resp_r;
		if (takeCycle) begin
			resp_nxt = RESP_OKAY;
			if (!mapped) begin
				resp_nxt = RESP_SLVERR;
			end else if (write && ((|pendHit) || statHit)) begin
				resp_nxt = RESP_SLVERR;
			end
		end
	end

	// Response register.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			resp_r <= RESP_OKAY;
		end else begin
			resp_r <= resp_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	// Every output leaves from a flip-flop here or in a word bank.
	assign readdata = readData_r;
	assign waitrequest = waitReq_r;
	assign response = resp_r;
	assign irqReq = reqFlat;
	assign irqLive = liveFlat;
	assign anyLive = anyLive_r;
	assign topLevel = topLevel_r;
	assign topSource = topSource_r;

endmodule : interrupt_enable_bank
`default_nettype wire

// ---- verilog/irq_enable_pkg.sv ----
// Constants, register map and carrier types shared by the interrupt enable bank.
package irq_enable_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_WORDS = 5;
	localparam int WORD_W = 16;
	localparam int PRIO_W = 3;
	localparam int SRC_IDX_W = 7;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;
	localparam int NUM_SRC = NUM_WORDS * WORD_W;

	// ****************************************************************
	// Implemented bit masks, one per enable and flag word
	// ****************************************************************
	localparam logic [WORD_W-1:0] IMPL_WORD0 = 16'h7FFF;
	localparam logic [WORD_W-1:0] IMPL_WORD1 = 16'hFFFB;
	localparam logic [WORD_W-1:0] IMPL_WORD2 = 16'hDFFF;
	localparam logic [WORD_W-1:0] IMPL_WORD3 = 16'h21FF;
	localparam logic [WORD_W-1:0] IMPL_WORD4 = 16'h00F6;
	localparam logic [NUM_WORDS-1:0][WORD_W-1:0] IMPL_MASK =
		{IMPL_WORD4, IMPL_WORD3, IMPL_WORD2, IMPL_WORD1, IMPL_WORD0};

	// Named positions of the word 0 enables inside the window.
	localparam int COMPARE1_IRQ_EN_BIT = 2;
	localparam int CAPTURE1_IRQ_EN_BIT = 1;
	localparam int EXT_PIN0_IRQ_EN_BIT = 0;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [WORD_W-1:0] ENABLE_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] FLAG_RESET = 16'h0000;
	localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;

	// ****************************************************************
	// Register map, byte addresses on the Avalon-MM slave
	// ****************************************************************
	localparam logic [NUM_WORDS-1:0][ADDR_W-1:0] EN_OFFSET =
		{8'h10, 8'h0C, 8'h08, 8'h04, 8'h00};
	localparam logic [NUM_WORDS-1:0][ADDR_W-1:0] FLAG_OFFSET =
		{8'h30, 8'h2C, 8'h28, 8'h24, 8'h20};
	localparam logic [NUM_WORDS-1:0][ADDR_W-1:0] PEND_OFFSET =
		{8'h60, 8'h5C, 8'h58, 8'h54, 8'h50};
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h40;

	// Status word fields.
	localparam int STAT_SRC_LSB = 0;
	localparam int STAT_LVL_LSB = 8;
	localparam int STAT_ANY_BIT = 12;

	// Avalon-MM response codes.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************************************
	// Carrier for one word's write strobe and data
	// ****************************************************************
	typedef struct packed {
		logic wrEnable;
		logic wrFlag;
		logic [1:0] laneEn;
		logic [WORD_W-1:0] data;
	} word_wr_s;

endpackage : irq_enable_pkg

// ---- verilog/irq_word_bank.sv ----
// One sixteen-bit word of enable bits and flag bits with its gated requests.
`timescale 1ns/1ps
`default_nettype none
module irq_word_bank #(
	parameter logic [15:0] IMPL = 16'hFFFF
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Register write port.
	input wire irq_enable_pkg::word_wr_s wordWr,
	// Source side.
	input wire logic [irq_enable_pkg::WORD_W-1:0] eventIn,
	input wire logic [irq_enable_pkg::WORD_W-1:0] prioOn,
	// Word state.
	output logic [irq_enable_pkg::WORD_W-1:0] enableBits,
	output logic [irq_enable_pkg::WORD_W-1:0] flagBits,
	output logic [irq_enable_pkg::WORD_W-1:0] reqBits,
	output logic [irq_enable_pkg::WORD_W-1:0] liveBits
);
	import irq_enable_pkg::*;

	logic [WORD_W-1:0] laneMask;
	logic [WORD_W-1:0] enable_r;
	logic [WORD_W-1:0] enable_nxt;
	logic [WORD_W-1:0] flag_r;
	logic [WORD_W-1:0] flag_nxt;
	logic [WORD_W-1:0] req_r;
	logic [WORD_W-1:0] live_r;

	// Byte lanes select which halves of the word a write touches.
	assign laneMask = {{8{wordWr.laneEn[1]}}, {8{wordWr.laneEn[0]}}};

	// Enable write merges written lanes; unimplemented bits stay zero.
	always_comb begin
		enable_nxt = enable_r;
		if (wordWr.wrEnable) begin
			enable_nxt = (enable_r & ~laneMask) | (wordWr.data & laneMask);
		end
		enable_nxt = enable_nxt & IMPL;
	end

	// Flags take software writes, but a source event wins over a clear.
	always_comb begin
		flag_nxt = flag_r;
		if (wordWr.wrFlag) begin
			flag_nxt = (flag_r & ~laneMask) | (wordWr.data & laneMask);
		end
		flag_nxt = (flag_nxt | eventIn) & IMPL;
	end

	// Enable register, cleared by reset so all sources start disabled.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			enable_r <= ENABLE_RESET;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	// Flag register, set regardless of the enable.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flag_r <= FLAG_RESET;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	// Gated requests, refreshed on every clock.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req_r <= FLAG_RESET;
			live_r <= FLAG_RESET;
		end else begin
			req_r <= flag_r & enable_r;
			live_r <= flag_r & enable_r & prioOn;
		end
	end

	assign enableBits = enable_r;
	assign flagBits = flag_r;
	assign reqBits = req_r;
	assign liveBits = live_r;

endmodule : irq_word_bank
`default_nettype wire

// ---- verif/interrupt_enable_bank_sva.sv ----
// Checker of bus timing and request outputs of the interrupt enable bank.
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_bank_sva (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Bus.
	input wire logic [irq_enable_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [irq_enable_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	input wire logic [1:0] response,
	// Sources and requests.
	input wire logic [irq_enable_pkg::NUM_SRC*irq_enable_pkg::PRIO_W-1:0] srcPriority,
	input wire logic [irq_enable_pkg::NUM_SRC-1:0] irqReq,
	input wire logic [irq_enable_pkg::NUM_SRC-1:0] irqLive,
	input wire logic anyLive,
	input wire logic [irq_enable_pkg::PRIO_W-1:0] topLevel
);
	import irq_enable_pkg::*;
	logic [NUM_SRC-1:0] prioOn;

	// ****
	// Helpers
	// ****
	// Marks each source whose priority field is not zero.
	always_comb begin
		for (int i = 0; i < NUM_SRC; i++) begin
			prioOn[i] = |srcPriority[i*PRIO_W +: PRIO_W];
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ****
	// Assertions
	// ****
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("waitrequest did not drop one cycle after the request");
	a_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest stayed low more than one cycle");
	a_unmapped_read: assert property (read && !waitrequest && address > 8'h60 |-> readdata == '0 && response == RESP_SLVERR)
		else $error("unmapped read not refused");
	a_read_high_zero: assert property (read && !waitrequest && address <= 8'h30 |-> readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_unimpl_req_low: assert property ((irqReq & ~IMPL_MASK) == '0)
		else $error("request on an unimplemented position");
	a_live_gated: assert property (irqLive == (irqReq & $past(prioOn)))
		else $error("live request does not follow priority gating");
	a_req_no_drop: assert property (|(~irqReq & $past(irqReq)) |-> $past(write) || $past(write, 2))
		else $error("request fell without a register write");
	a_any_from_live: assert property (anyLive == $past(|irqLive))
		else $error("anyLive does not follow live requests");
	a_level_any: assert property (anyLive == (topLevel != 3'h0))
		else $error("topLevel disagrees with anyLive");

	// Main scenarios reached.
	c_live: cover property (anyLive);
	c_refused: cover property (read && !waitrequest && response == RESP_SLVERR);
	c_masked: cover property (|irqReq && !anyLive);
endmodule : interrupt_enable_bank_sva

bind interrupt_enable_bank interrupt_enable_bank_sva chk (.clk_sys, .rst_n, .address, .read, .write, .readdata,
	.waitrequest, .response, .srcPriority, .irqReq, .irqLive, .anyLive, .topLevel);
`default_nettype wire

// ---- verif/interrupt_enable_bank_bench.sv ----
// Self-checking bench for the interrupt enable bank over its Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_bank_bench;
	import irq_enable_pkg::*;
	// Design inputs.
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [DATA_W-1:0] writedata = 32'h00000000;
	logic [BE_W-1:0] byteenable = 4'h0;
	logic [NUM_SRC-1:0] srcEvent = '0;
	logic [NUM_SRC*PRIO_W-1:0] srcPriority = '0;
	// Design outputs and bench state.
	logic [DATA_W-1:0] readdata;
	logic waitrequest;
	logic [1:0] response;
	logic [NUM_SRC-1:0] irqReq;
	logic [NUM_SRC-1:0] irqLive;
	logic anyLive;
	logic [PRIO_W-1:0] topLevel;
	logic [SRC_IDX_W-1:0] topSource;
	int badCount = 0;
	int cmpCount = 0;
	int cycles = 0;

	interrupt_enable_bank dut (.clk_sys, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
		.waitrequest, .response, .srcEvent, .srcPriority, .irqReq, .irqLive, .anyLive, .topLevel, .topSource);

	// ****
	// Clock, timeout and tasks
	// ****
	// Free-running 100 MHz clock.
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// Ends a hung run as a failure.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			badCount++;
			results();
		end
	end

	task automatic results();
		if (badCount == 0 && cmpCount > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	task automatic check(input string what, input logic [NUM_SRC-1:0] expVal, input logic [NUM_SRC-1:0] gotVal);
		cmpCount++;
		if (gotVal !== expVal) begin
			badCount++;
			$display("wrong value %s expected %h seen %h", what, expVal, gotVal);
		end
	endtask : check

	// The request is held until the edge that samples waitrequest low.
	task automatic busWrite(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d, input logic [BE_W-1:0] be);
		@(posedge clk_sys);
		address <= a;
		writedata <= {16'h0000, d};
		byteenable <= be;
		write <= 1'b1;
		@(posedge clk_sys iff waitrequest === 1'b0);
		write <= 1'b0;
	endtask : busWrite

	task automatic rdChk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] r);
		@(posedge clk_sys);
		address <= a;
		read <= 1'b1;
		@(posedge clk_sys iff waitrequest === 1'b0);
		check(what, NUM_SRC'(d), NUM_SRC'(readdata));
		check("response", NUM_SRC'(r), NUM_SRC'(response));
		read <= 1'b0;
	endtask : rdChk

	task automatic pulse(input int n);
		@(posedge clk_sys);
		srcEvent[n] <= 1'b1;
		@(posedge clk_sys);
		srcEvent[n] <= 1'b0;
	endtask : pulse

	// ****
	// Test sequence
	// ****
	// Register map first, then the request path of one source.
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check("irqReq at reset", '0, irqReq);
		for (int k = 0; k < NUM_WORDS; k++) begin
			rdChk("enable reset", EN_OFFSET[k], 32'h00000000, RESP_OKAY);
			busWrite(EN_OFFSET[k], 16'hFFFF, 4'h3);
			rdChk("enable mask", EN_OFFSET[k], {16'h0000, IMPL_MASK[k]}, RESP_OKAY);
			busWrite(EN_OFFSET[k], 16'h0000, 4'h1);
			rdChk("enable lane", EN_OFFSET[k], {16'h0000, IMPL_MASK[k] & 16'hFF00}, RESP_OKAY);
			busWrite(EN_OFFSET[k], 16'h0000, 4'h3);
		end
		busWrite(8'h70, 16'hFFFF, 4'h3);
		rdChk("unmapped", 8'h70, 32'h00000000, RESP_SLVERR);
		srcPriority[8:6] <= 3'h5;
		pulse(2);
		pulse(15);
		repeat (4) @(posedge clk_sys);
		check("irqReq disabled", '0, irqReq);
		rdChk("flag", FLAG_OFFSET[0], 32'h00000004, RESP_OKAY);
		busWrite(EN_OFFSET[0], 16'h0004, 4'h3);
		repeat (4) @(posedge clk_sys);
		check("irqReq enabled", 80'h4, irqReq);
		check("irqLive", 80'h4, irqLive);
		check("winner", 80'h682, NUM_SRC'({anyLive, topLevel, topSource}));
		rdChk("pending", PEND_OFFSET[0], 32'h00000004, RESP_OKAY);
		rdChk("status", STATUS_OFFSET, 32'h00001502, RESP_OKAY);
		srcPriority[8:6] <= 3'h0;
		repeat (4) @(posedge clk_sys);
		check("irqLive off", '0, irqLive);
		check("irqReq kept", 80'h4, irqReq);
		busWrite(EN_OFFSET[0], 16'h0000, 4'h3);
		repeat (4) @(posedge clk_sys);
		check("irqReq cleared", '0, irqReq);
		busWrite(FLAG_OFFSET[0], 16'h0000, 4'h3);
		rdChk("flag cleared", FLAG_OFFSET[0], 32'h00000000, RESP_OKAY);
		results();
	end
endmodule : interrupt_enable_bank_bench
`default_nettype wire
